// ---- rtl/playback_pkg.sv ----
// Constants, field layouts and carrier types of the playback control bank.
// Assumes a 100 MHz reference clock and 8-bit registers on 32-bit words.
package playback_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int ZC_MIN_TMO_NS = 2_500_000;
	localparam int ZC_MIN_TMO_CYC = ZC_MIN_TMO_NS / CLK_PERIOD_NS;

	localparam int ADDR_W   = 18;
	localparam int SAMPLE_W = 24;

	localparam logic [15:0] IDX_SPEAKER = 16'h4027;
	localparam logic [15:0] IDX_BEEP_ZC = 16'h4028;
	localparam logic [15:0] IDX_POWER   = 16'h4029;
	localparam logic [15:0] IDX_DAC     = 16'h402A;
	localparam logic [15:0] IDX_ATT_L   = 16'h402B;
	localparam logic [15:0] IDX_ATT_R   = 16'h402C;
	localparam logic [15:0] IDX_PADS    = 16'h402D;

	localparam int SPK_GAIN_LSB = 6;
	localparam int SPK_EN_BIT   = 0;
	localparam int ZC_TMO_LSB   = 3;
	localparam int ZC_EN_BIT    = 0;
	localparam int SPK_BIAS_LSB = 6;
	localparam int DAC_BIAS_LSB = 4;
	localparam int BE_BIAS_LSB  = 2;
	localparam int BE_R_BIT     = 1;
	localparam int BE_L_BIT     = 0;
	localparam int MONO_LSB     = 6;
	localparam int INVERT_BIT   = 5;
	localparam int DEEMPH_BIT   = 2;
	localparam int DAC_EN_LSB   = 0;

	localparam logic [7:0] RST_SPEAKER = 8'h00;
	localparam logic [7:0] RST_BEEP_ZC = 8'h19;
	localparam logic [7:0] RST_POWER   = 8'h00;
	localparam logic [7:0] RST_DAC     = 8'h00;
	localparam logic [7:0] RST_ATT     = 8'h00;
	localparam logic [7:0] RST_PADS    = 8'hFF;

	localparam int DEEMPH_SHIFT = 2;

	typedef enum logic [1:0] {
		MONO_STEREO = 2'h0,
		MONO_LEFT   = 2'h1,
		MONO_RIGHT  = 2'h2,
		MONO_MIX    = 2'h3
	} mono_mode_t;

	typedef enum logic [2:0] {
		BIAS_NORMAL,
		BIAS_POWER_SAVE,
		BIAS_EXTREME_SAVE,
		BIAS_ENHANCED,
		BIAS_RESERVED
	} bias_mode_t;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} stereo_t;

	typedef struct packed {
		logic [1:0] spk_gain;
		logic       spk_en;
		bias_mode_t spk_bias;
		bias_mode_t dac_bias;
		bias_mode_t be_bias;
		logic       be_right_en;
		logic       be_left_en;
		logic       dac_right_en;
		logic       dac_left_en;
		logic       deemph_en;
		mono_mode_t mono;
		logic [7:0] att_left;
		logic [7:0] att_right;
		logic [3:0] pull_up;
		logic [3:0] pull_down;
	} playback_ctrl_t;

endpackage

// ---- rtl/playback_path_control_bank.sv ----
// Playback control bank: registers, beep zero-cross timing, DAC routing.
// Assumes an Avalon-MM master, a one-cycle frame tick and beep strobes
// synchronous to ref_clk.
//
// Overview of operation
// [RQ1] Pending beep gain waits for zero cross at most 20/10/5/2.5 ms.
// [RQ2] One bit enables the zero-cross detector; resets enabled, timeout 11.
// [RQ3] Speaker gain codes give 0, 2, 4, 6 dB; gain and enable reset off.
// [RQ4] Bit 1 enables right back end, bit 0 left; both reset off.
// [RQ5] Speaker bias 00 normal, 01 power saving, 10 enhanced; resets 00.
// [RQ6] DAC and back-end bias 00 normal, 01 extreme, 10 power saving.
// [RQ7] Mono mode 00 sends each channel to its own output; reset value.
// [RQ8] Mono mode 01 sends left input to both outputs.
// [RQ9] Mono mode 10 sends right input to both outputs.
// [RQ10] Mono mode 11 sends the left and right mix to both outputs.
// [RQ11] Polarity bit inverts DAC output when set; resets clear.
// [RQ12] De-emphasis bit inserts a de-emphasis filter; resets off.
// [RQ13] DAC enable field switches left and right DACs; resets both off.
// [RQ14] Eight-bit attenuation per channel, 0.375 dB per code, resets zero.
// [RQ15] Applied attenuation moves one step per audio frame toward target.
// [RQ16] Four pad pull fields: 00 up, 10 none, 11 down; reset 11.
// [RQ17] Enabled detector applies beep gain at crossing or timeout first.
// [RQ18] Disabled detector applies beep gain immediately after the write.
// [RQ19] Bias code 11 is enhanced for DAC and back end, reserved for speaker.
`timescale 1ns/1ps

module playback_path_control_bank
	import playback_pkg::*;
#(
	parameter int ZC_BASE_CYC = ZC_MIN_TMO_CYC
) (
	input  wire logic              ref_clk,         // 100 MHz clock
	input  wire logic              resetn,          // async reset
	input  wire logic [ADDR_W-1:0] avs_address,     // byte address
	input  wire logic              avs_read,        // read request
	input  wire logic              avs_write,       // write request
	input  wire logic [31:0]       avs_writedata,   // write data
	input  wire logic [3:0]        avs_byteenable,  // byte lanes
	output logic [31:0]            avs_readdata,    // read data
	output logic                   avs_waitrequest, // stall
	input  wire logic              beep_gain_req,   // gain change pulse
	input  wire logic              beep_zero_cross, // crossing pulse
	output logic                   beep_gain_apply, // apply pulse
	input  wire logic              frame_tick,      // one per frame
	input  wire stereo_t           pcm_in,          // samples in
	output stereo_t                pcm_out,         // samples out
	output playback_ctrl_t         ctrl             // decoded controls
);

	typedef enum logic {ZC_IDLE, ZC_WAIT} zc_state_t;

	logic             rst_meta_q;
	logic             rst_n;
	logic [7:0]       spk_q;
	logic [7:0]       zc_q;
	logic [7:0]       pwr_q;
	logic [7:0]       dac_q;
	logic [7:0]       pad_q;
	logic [7:0]       att_tgt_q [2];
	logic [7:0]       att_app_q [2];
	logic             wait_q;
	logic [31:0]      rdata_q;
	logic             wr_fire;
	logic [15:0]      idx;
	zc_state_t        zc_state_q;
	logic [31:0]      zc_cnt_q;
	logic [31:0]      zc_lim_q;
	logic             apply_q;
	stereo_t          pcm_q;
	playback_ctrl_t   ctrl_q;
	logic signed [SAMPLE_W-1:0] src   [2];
	logic signed [SAMPLE_W-1:0] emph_q [2];
	logic signed [SAMPLE_W:0]   mix;

	function automatic logic [15:0] word_index(logic [ADDR_W-1:0] a);
		return a[ADDR_W-1:2];
	endfunction

	function automatic bias_mode_t bias_decode(logic [1:0] c, logic spk);
		unique case (c)
			2'h0: return BIAS_NORMAL;
			2'h1: return spk ? BIAS_POWER_SAVE : BIAS_EXTREME_SAVE;
			2'h2: return spk ? BIAS_ENHANCED : BIAS_POWER_SAVE;
			2'h3: return spk ? BIAS_RESERVED : BIAS_ENHANCED;
		endcase
	endfunction

	// Timeout doubles for each code step below the shortest one.
	function automatic logic [31:0] zc_limit(logic [1:0] code);
		logic [31:0] base;
		base = 32'(ZC_BASE_CYC);
		return base << (2'h3 - code);
	endfunction

	// Reset release goes through two flops so every flop leaves reset
	// on the same edge.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	assign idx     = word_index(avs_address);
	assign wr_fire = avs_write && !wait_q && avs_byteenable[0];

	// Every access takes exactly one wait cycle.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q <= 1'b1;
		end else if ((avs_read || avs_write) && wait_q) begin
			wait_q <= 1'b0;
		end else begin
			wait_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read && wait_q) begin
			unique case (idx)
				IDX_SPEAKER: rdata_q <= {24'h000000, spk_q};
				IDX_BEEP_ZC: rdata_q <= {24'h000000, zc_q};
				IDX_POWER:   rdata_q <= {24'h000000, pwr_q};
				IDX_DAC:     rdata_q <= {24'h000000, dac_q};
				IDX_ATT_L:   rdata_q <= {24'h000000, att_tgt_q[0]};
				IDX_ATT_R:   rdata_q <= {24'h000000, att_tgt_q[1]};
				IDX_PADS:    rdata_q <= {24'h000000, pad_q};
				default:     rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Reserved bits are stored as written; they steer nothing.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			spk_q <= RST_SPEAKER; // RQ3
			zc_q  <= RST_BEEP_ZC; // RQ2
			pwr_q <= RST_POWER; // RQ4
			dac_q <= RST_DAC; // RQ7
			pad_q <= RST_PADS; // RQ16
			att_tgt_q[0] <= RST_ATT; // RQ14
			att_tgt_q[1] <= RST_ATT; // RQ14
		end else if (wr_fire) begin
			unique case (idx)
				IDX_SPEAKER: spk_q <= avs_writedata[7:0];
				IDX_BEEP_ZC: zc_q <= avs_writedata[7:0];
				IDX_POWER:   pwr_q <= avs_writedata[7:0];
				IDX_DAC:     dac_q <= avs_writedata[7:0];
				IDX_ATT_L:   att_tgt_q[0] <= avs_writedata[7:0];
				IDX_ATT_R:   att_tgt_q[1] <= avs_writedata[7:0];
				IDX_PADS:    pad_q <= avs_writedata[7:0];
				default:     ;
			endcase
		end
	end

	// Beep gain timing. A request that arrives while one is pending is
	// folded into it, since the gain lives outside this block.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			zc_state_q <= ZC_IDLE;
			zc_cnt_q   <= 32'h0000_0000;
			zc_lim_q   <= 32'h0000_0001;
			apply_q    <= 1'b0;
		end else begin
			apply_q <= 1'b0;
			unique case (zc_state_q)
				ZC_IDLE: begin
					if (beep_gain_req && !zc_q[ZC_EN_BIT]) begin
						apply_q <= 1'b1; // RQ18
					end else if (beep_gain_req) begin
						zc_state_q <= ZC_WAIT;
						zc_cnt_q   <= 32'h0000_0000;
						zc_lim_q   <= zc_limit(zc_q[ZC_TMO_LSB+:2]); // RQ1
					end
				end
				ZC_WAIT: begin
					if (beep_zero_cross || !zc_q[ZC_EN_BIT] ||
					    zc_cnt_q == zc_lim_q - 32'h0000_0001) begin
						apply_q    <= 1'b1; // RQ17
						zc_state_q <= ZC_IDLE;
					end else begin
						zc_cnt_q <= zc_cnt_q + 32'h0000_0001; // RQ1
					end
				end
			endcase
		end
	end

	always_comb begin
		mix = (SAMPLE_W+1)'(pcm_in.left) + (SAMPLE_W+1)'(pcm_in.right);
		unique case (mono_mode_t'(dac_q[MONO_LSB+:2]))
			MONO_STEREO: begin
				src[0] = pcm_in.left; // RQ7
				src[1] = pcm_in.right; // RQ7
			end
			MONO_LEFT: begin
				src[0] = pcm_in.left; // RQ8
				src[1] = pcm_in.left; // RQ8
			end
			MONO_RIGHT: begin
				src[0] = pcm_in.right; // RQ9
				src[1] = pcm_in.right; // RQ9
			end
			MONO_MIX: begin
				src[0] = mix[SAMPLE_W:1]; // RQ10
				src[1] = mix[SAMPLE_W:1]; // RQ10
			end
		endcase
	end

	// Per channel: de-emphasis, slew, attenuation, polarity and enable.
	// Attenuation here uses whole 6 dB shifts (16 codes); the fine
	// 0.375 dB part is left to the analog gain that reads ctrl.
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic signed [SAMPLE_W-1:0] filt;
		logic signed [SAMPLE_W-1:0] atten;
		logic signed [SAMPLE_W-1:0] shaped;
		logic signed [SAMPLE_W-1:0] step;

		assign step  = (src[ch] - emph_q[ch]) >>> DEEMPH_SHIFT;
		assign filt  = dac_q[DEEMPH_BIT] ? emph_q[ch] : src[ch]; // RQ12
		assign atten = filt >>> att_app_q[ch][7:4]; // RQ14
		// Negating full scale wraps; the attenuator lets it reach at any applied code below 16.
		assign shaped = dac_q[INVERT_BIT] ? -atten : atten; // RQ11

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				emph_q[ch] <= '0;
			end else if (frame_tick) begin
				emph_q[ch] <= emph_q[ch] + step; // RQ12
			end
		end

		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				att_app_q[ch] <= RST_ATT;
			end else if (frame_tick) begin
				if (att_app_q[ch] < att_tgt_q[ch]) begin
					att_app_q[ch] <= att_app_q[ch] + 8'h01; // RQ15
				end else if (att_app_q[ch] > att_tgt_q[ch]) begin
					att_app_q[ch] <= att_app_q[ch] - 8'h01; // RQ15
				end
			end
		end

		// One process per half of the output word, so no flop has two drivers.
		if (ch == 0) begin : g_left
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pcm_q.left <= '0;
				end else if (frame_tick) begin
					pcm_q.left <= dac_q[DAC_EN_LSB] ? shaped : '0; // RQ13
				end
			end
		end else begin : g_right
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pcm_q.right <= '0;
				end else if (frame_tick) begin
					pcm_q.right <= dac_q[DAC_EN_LSB+1] ? shaped : '0; // RQ13
				end
			end
		end
	end

	// Pad p uses field [2p+1:2p]; reserved code 01 applies no pull.
	for (genvar p = 0; p < 4; p++) begin : g_pad
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				ctrl_q.pull_up[p]   <= 1'b0;
				ctrl_q.pull_down[p] <= 1'b1;
			end else begin
				ctrl_q.pull_up[p]   <= pad_q[2*p+:2] == 2'h0; // RQ16
				ctrl_q.pull_down[p] <= pad_q[2*p+:2] == 2'h3; // RQ16
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q.spk_gain     <= 2'h0;
			ctrl_q.spk_en       <= 1'b0;
			ctrl_q.spk_bias     <= BIAS_NORMAL;
			ctrl_q.dac_bias     <= BIAS_NORMAL;
			ctrl_q.be_bias      <= BIAS_NORMAL;
			ctrl_q.be_right_en  <= 1'b0;
			ctrl_q.be_left_en   <= 1'b0;
			ctrl_q.dac_right_en <= 1'b0;
			ctrl_q.dac_left_en  <= 1'b0;
			ctrl_q.deemph_en    <= 1'b0;
			ctrl_q.mono         <= MONO_STEREO;
			ctrl_q.att_left     <= RST_ATT;
			ctrl_q.att_right    <= RST_ATT;
		end else begin
			ctrl_q.spk_gain <= spk_q[SPK_GAIN_LSB+:2]; // RQ3
			ctrl_q.spk_en   <= spk_q[SPK_EN_BIT]; // RQ3
			ctrl_q.spk_bias <= bias_decode(pwr_q[SPK_BIAS_LSB+:2],
				1'b1); // RQ5 RQ19
			ctrl_q.dac_bias <= bias_decode(pwr_q[DAC_BIAS_LSB+:2],
				1'b0); // RQ6 RQ19
			ctrl_q.be_bias  <= bias_decode(pwr_q[BE_BIAS_LSB+:2],
				1'b0); // RQ6 RQ19
			ctrl_q.be_right_en  <= pwr_q[BE_R_BIT]; // RQ4
			ctrl_q.be_left_en   <= pwr_q[BE_L_BIT]; // RQ4
			ctrl_q.dac_right_en <= dac_q[DAC_EN_LSB+1]; // RQ13
			ctrl_q.dac_left_en  <= dac_q[DAC_EN_LSB]; // RQ13
			ctrl_q.deemph_en    <= dac_q[DEEMPH_BIT]; // RQ12
			ctrl_q.mono         <= mono_mode_t'(dac_q[MONO_LSB+:2]);
			ctrl_q.att_left     <= att_app_q[0]; // RQ14
			ctrl_q.att_right    <= att_app_q[1]; // RQ14
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign beep_gain_apply = apply_q;
	assign pcm_out         = pcm_q;
	assign ctrl            = ctrl_q;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence s_req_idle_off;
		zc_state_q == ZC_IDLE && beep_gain_req && !zc_q[ZC_EN_BIT];
	endsequence

	sequence s_wait_cross;
		zc_state_q == ZC_WAIT && beep_zero_cross;
	endsequence

	sequence s_wait_expire;
		zc_state_q == ZC_WAIT && zc_q[ZC_EN_BIT] &&
			zc_cnt_q == zc_lim_q - 32'h0000_0001;
	endsequence

	a_bus_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait cycle");

	a_zc_immediate: assert property ( // RQ18
		s_req_idle_off |=> beep_gain_apply && zc_state_q == ZC_IDLE)
		else $error("disabled detector did not apply at once");

	a_zc_crossing: assert property ( // RQ17
		s_wait_cross |=> beep_gain_apply && zc_state_q == ZC_IDLE)
		else $error("zero crossing did not apply gain");

	a_zc_timeout: assert property ( // RQ1
		s_wait_expire |=> beep_gain_apply ##1 !beep_gain_apply)
		else $error("timeout did not force a single apply");

	a_zc_limit_code: assert property ( // RQ1
		zc_state_q == ZC_IDLE && beep_gain_req && zc_q[ZC_EN_BIT] &&
		zc_q[ZC_TMO_LSB+:2] == 2'h0 |=> zc_lim_q == 32'(ZC_BASE_CYC) * 8)
		else $error("longest timeout limit wrong");

	a_zc_reset_val: assert property ( // RQ2
		$rose(rst_n) |-> zc_q == RST_BEEP_ZC && pad_q == RST_PADS)
		else $error("reset value of detector or pads wrong");

	a_slew_step: assert property ( // RQ15
		frame_tick && att_app_q[0] < att_tgt_q[0]
		|=> att_app_q[0] == $past(att_app_q[0]) + 8'h01)
		else $error("attenuation did not step up by one");

	a_slew_hold: assert property ( // RQ15
		!frame_tick |=> att_app_q[1] == $past(att_app_q[1]))
		else $error("attenuation moved without a frame");

	a_mono_left: assert property ( // RQ8
		frame_tick && dac_q[MONO_LSB+:2] == MONO_LEFT &&
		dac_q[DAC_EN_LSB+:2] == 2'h3 && !dac_q[DEEMPH_BIT] &&
		att_app_q[0] == att_app_q[1] |=> pcm_out.left == pcm_out.right)
		else $error("left mono mode outputs differ");

	a_dac_off: assert property ( // RQ13
		frame_tick && !dac_q[DAC_EN_LSB] |=> pcm_out.left == '0)
		else $error("disabled left DAC not silent");

	a_write_effect: assert property (
		wr_fire && idx == IDX_DAC |=> dac_q == $past(avs_writedata[7:0]))
		else $error("DAC control write lost");

endmodule

// ---- tb/tb_playback_path_control_bank.sv ----
// Self-checking bench for the playback control bank.
// Assumes the Avalon slave answers with one wait state and a short beep base.
`timescale 1ns/1ps

module tb_playback_path_control_bank;
	import playback_pkg::*;

	localparam int ZC = 20;

	logic              ref_clk         = 1'b0;
	logic              resetn          = 1'b0;
	logic [ADDR_W-1:0] avs_address     = '0;
	logic              avs_read        = 1'b0;
	logic              avs_write       = 1'b0;
	logic [31:0]       avs_writedata   = '0;
	logic [3:0]        avs_byteenable  = 4'hF;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              beep_gain_req   = 1'b0;
	logic              beep_zero_cross = 1'b0;
	logic              beep_gain_apply;
	logic              frame_tick      = 1'b0;
	stereo_t           pcm_in          = '0;
	stereo_t           pcm_out;
	playback_ctrl_t    ctrl;
	int                fail_count      = 0;
	int                cmp_count       = 0;
	int                cycles          = 0;
	logic [31:0]       rdata;

	playback_path_control_bank #(.ZC_BASE_CYC(ZC)) u_playback_path_control_bank (
		.ref_clk         (ref_clk),
		.resetn          (resetn),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.beep_gain_req   (beep_gain_req),
		.beep_zero_cross (beep_zero_cross),
		.beep_gain_apply (beep_gain_apply),
		.frame_tick      (frame_tick),
		.pcm_in          (pcm_in),
		.pcm_out         (pcm_out),
		.ctrl            (ctrl)
	);

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end

	// A hung handshake would otherwise stall the run forever.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			test_done();
		end
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [47:0] exp,
			input logic [47:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// The request is held until the edge that samples waitrequest low.
	task automatic bus(input logic rd, input logic [15:0] idx,
			input logic [7:0] wd, input logic [3:0] be);
		@(posedge ref_clk);
		avs_address    <= {idx, 2'b00};
		avs_read       <= rd;
		avs_write      <= !rd;
		avs_writedata  <= {24'h0, wd};
		avs_byteenable <= be;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		bus(1'b0, idx, d, 4'hF);
	endtask

	task automatic settle();
		repeat (2) @(posedge ref_clk);
		#1;
	endtask

	task automatic frame(input logic [23:0] l, input logic [23:0] r);
		@(posedge ref_clk);
		frame_tick <= 1'b1;
		pcm_in     <= {l, r};
		@(posedge ref_clk);
		frame_tick <= 1'b0;
		@(negedge ref_clk);
	endtask

	task automatic t_reset();
		logic [15:0] ix [7];
		logic [7:0]  rv [7];
		ix = '{16'h4027, 16'h4028, 16'h4029, 16'h402A, 16'h402B, 16'h402C,
			16'h402D};
		rv = '{8'h00, 8'h19, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
		for (int i = 0; i < 7; i++) begin
			bus(1'b1, ix[i], 8'h00, 4'hF);
			chk("reset_reg", {40'h0, rv[i]}, {16'h0, rdata});
		end
		chk("reset_pulls", 8'h0F, {ctrl.pull_up, ctrl.pull_down});
		chk("reset_mono", MONO_STEREO, ctrl.mono);
		chk("reset_dacen", 2'b00, {ctrl.dac_right_en, ctrl.dac_left_en});
		chk("reset_bias", {3{BIAS_NORMAL}},
			{ctrl.spk_bias, ctrl.dac_bias, ctrl.be_bias});
		for (int i = 0; i < 7; i++) begin
			wr(ix[i], 8'hA5 ^ 8'(i));
			bus(1'b1, ix[i], 8'h00, 4'hF);
			chk("readback", 8'hA5 ^ 8'(i), rdata);
		end
		bus(1'b0, 16'h402D, 8'h00, 4'hE);
		bus(1'b1, 16'h402D, 8'h00, 4'hF);
		chk("lane_masked", 8'hA3, rdata);
		bus(1'b1, 16'h4100, 8'h00, 4'hF);
		chk("unmapped", 32'h0, rdata);
		$display("test reset and access done");
	endtask

	task automatic t_power();
		bias_mode_t sb [4];
		bias_mode_t db [4];
		sb = '{BIAS_NORMAL, BIAS_POWER_SAVE, BIAS_ENHANCED, BIAS_RESERVED};
		db = '{BIAS_NORMAL, BIAS_EXTREME_SAVE, BIAS_POWER_SAVE, BIAS_ENHANCED};
		for (int c = 0; c < 4; c++) begin
			wr(16'h4027, {2'(c), 6'h01});
			wr(16'h4029, {2'(c), 2'(c), 2'(c), 2'b10});
			settle();
			chk("spk_gain", {2'(c), 1'b1}, {ctrl.spk_gain, ctrl.spk_en});
			chk("spk_bias", sb[c], ctrl.spk_bias);
			chk("dac_bias", db[c], ctrl.dac_bias);
			chk("be_bias", db[c], ctrl.be_bias);
			chk("be_en", 2'b10, {ctrl.be_right_en, ctrl.be_left_en});
		end
		wr(16'h402D, 8'h2D);
		settle();
		chk("pulls", 8'h82, {ctrl.pull_up, ctrl.pull_down});
		$display("test power and pads done");
	endtask

	task automatic t_audio();
		logic [23:0] el;
		logic [23:0] er;
		wr(16'h402B, 8'h00);
		wr(16'h402C, 8'h00);
		repeat (4) frame(24'h0, 24'h0);
		for (int m = 0; m < 4; m++) begin
			wr(16'h402A, {2'(m), 6'h03});
			frame(24'h000100, 24'h000040);
			el = (m == 2) ? 24'h40 : (m == 3) ? 24'hA0 : 24'h100;
			er = (m == 1) ? 24'h100 : (m == 3) ? 24'hA0 : 24'h40;
			chk("mono_out", {el, er}, pcm_out);
			chk("mono_field", m, ctrl.mono);
		end
		wr(16'h402A, 8'h23);
		frame(24'h000100, 24'h000040);
		chk("invert", {24'hFFFF00, 24'hFFFFC0}, pcm_out);
		for (int e = 0; e < 4; e++) begin
			wr(16'h402A, {6'h00, 2'(e)});
			frame(24'h000100, 24'h000040);
			el = e[0] ? 24'h100 : 24'h0;
			er = e[1] ? 24'h40 : 24'h0;
			chk("dac_enable", {el, er}, pcm_out);
			chk("dac_en_field", e, {ctrl.dac_right_en, ctrl.dac_left_en});
		end
		// With the filter in, a step input reaches the output gradually.
		wr(16'h402A, 8'h07);
		repeat (8) frame(24'h0, 24'h0);
		frame(24'h000400, 24'h000400);
		el = pcm_out.left;
		chk("deemph_step", 1'b1, el < 24'h400);
		frame(24'h000400, 24'h000400);
		chk("deemph_rise", 1'b1, pcm_out.left > el);
		chk("deemph_en", 1'b1, ctrl.deemph_en);
		$display("test audio path done");
	endtask

	task automatic t_atten();
		wr(16'h402B, 8'h05);
		wr(16'h402C, 8'hFF);
		repeat (5) @(posedge ref_clk);
		#1;
		chk("att_hold", 8'h00, ctrl.att_left);
		for (int k = 1; k < 8; k++) begin
			frame(24'h0, 24'h0);
			@(negedge ref_clk);
			chk("att_left", (k < 5) ? k : 5, ctrl.att_left);
			chk("att_right", 8'(k), ctrl.att_right);
		end
		wr(16'h402B, 8'h02);
		for (int k = 4; k > 1; k--) begin
			frame(24'h0, 24'h0);
			@(negedge ref_clk);
			chk("att_down", 8'(k), ctrl.att_left);
		end
		bus(1'b1, 16'h402C, 8'h00, 4'hF);
		chk("att_target", 32'hFF, rdata);
		$display("test attenuation slew done");
	endtask

	task automatic req_wait(output int n);
		@(posedge ref_clk);
		beep_gain_req <= 1'b1;
		@(posedge ref_clk);
		beep_gain_req <= 1'b0;
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (beep_gain_apply !== 1'b1 && n < 400);
	endtask

	task automatic t_beep();
		int n;
		int lim;
		for (int c = 0; c < 4; c++) begin
			wr(16'h4028, {3'b000, 2'(c), 3'b001});
			lim = ZC * (8 >> c);
			req_wait(n);
			chk("zc_timeout", lim + 1, n);
		end
		@(posedge ref_clk);
		beep_gain_req <= 1'b1;
		@(posedge ref_clk);
		beep_gain_req <= 1'b0;
		repeat (3) @(negedge ref_clk);
		chk("zc_waiting", 1'b0, beep_gain_apply);
		@(posedge ref_clk);
		beep_zero_cross <= 1'b1;
		@(posedge ref_clk);
		beep_zero_cross <= 1'b0;
		@(negedge ref_clk);
		chk("zc_apply", 1'b1, beep_gain_apply);
		@(negedge ref_clk);
		chk("zc_pulse", 1'b0, beep_gain_apply);
		wr(16'h4028, 8'h18);
		req_wait(n);
		chk("zc_off", 1, n);
		$display("test beep timing done");
	endtask

	initial begin
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		#1;
		t_reset();
		t_power();
		t_audio();
		t_atten();
		t_beep();
		test_done();
	end

endmodule
